/* File: bmpc_top.sv */
// buck channel mode, current limit, phase and pairing control with ahb-lite registers
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module bmpc_top
   import bmpc_pkg::*;
#(
   parameter int SETTLE_CYC = BMPC_SETTLE_CYC
)
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              clk_en,
   input  wire bmpc_otp_t         otp,
   input  wire logic              hsel,
   input  wire logic [7:0]        haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic      [7:0]        eff_mode,
   output logic      [7:0]        eff_ilim,
   output logic      [11:0]       eff_phase,
   output logic      [51:0]       ilim_ma,
   output logic      [35:0]       phase_deg,
   output logic                   irq_out_n
);

   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   initial
   begin
      if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
         $error("SETTLE_CYC out of range");
   end

   typedef enum logic [1:0] {ST_LOAD, ST_RUN} bmpc_state_t;

   typedef struct packed {
      bmpc_state_t       st;
      logic [7:0]        mode;       // requested run mode per channel
      logic [7:0]        act;        // active mode per channel
      logic [3:0][15:0]  cnt;        // transition timers
      logic [7:0]        ilim;
      logic [11:0]       ph;
      logic [7:0]        stby;
      logic [3:0]        stat;
      logic [3:0]        mask;
      logic [1:0]        pair_a;
      logic [1:0]        pair_b;
      logic              dph_v;
      logic              dph_wr;
      logic [7:0]        dph_a;
      logic [31:0]       rdata;
      logic              irq_n;
      logic [7:0]        o_mode;
      logic [7:0]        o_ilim;
      logic [11:0]       o_ph;
   } bmpc_regs_t;

   bmpc_regs_t  s_ff;
   bmpc_regs_t  nxt_s;
   logic        a_dual;
   logic        b_dual;
   logic [51:0] ma_w;
   logic [35:0] deg_w;
   logic [3:0]  done_w;

   // reserved pair codes count as not dual
   assign a_dual = (s_ff.pair_a == BMPC_PAIR_DUAL);
   assign b_dual = (s_ff.pair_b == BMPC_PAIR_DUAL);

   // ---------------------------------------------------------------
   // per-channel decoders
   // ---------------------------------------------------------------
   for (genvar g = 0; g < BMPC_NCH; g++)
   begin : g_dec
      bmpc_ilim_decode u_il (
         .code     (s_ff.o_ilim[2*g +: 2]),
         .limit_ma (ma_w[13*g +: 13])
      );
      bmpc_phase_decode u_ph (
         .code    (s_ff.o_ph[3*g +: 3]),
         .degrees (deg_w[9*g +: 9])
      );
      // a timer that reaches one below the settle count marks a finished transition
      assign done_w[g] = (s_ff.act[2*g +: 2] != s_ff.mode[2*g +: 2])
                         && (s_ff.cnt[g] == 16'(SETTLE_CYC - 1));
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [31:0] rd;
      logic [3:0]  set;
      rd    = 32'h0000_0000;
      set   = 4'h0;
      nxt_s = s_ff;
      if (s_ff.st == ST_LOAD)
      begin
         // limit, phase, standby and pairing defaults come from the programmed fields, modes start in pwm
         nxt_s.ilim   = {otp.ilim_def[3], otp.ilim_def[2], otp.ilim_def[1], otp.ilim_def[0]};
         nxt_s.ph     = otp.ph_def;
         for (int i = 0; i < BMPC_NCH; i++)
            nxt_s.stby[2*i +: 2] = otp.stby_def[i] ? BMPC_MODE_PFM : BMPC_MODE_OFF;
         nxt_s.pair_a = otp.pair_a;
         nxt_s.pair_b = otp.pair_b;
         nxt_s.mode   = {4{BMPC_MODE_PWM}};
         nxt_s.act    = {4{BMPC_MODE_PWM}};
         nxt_s.st     = ST_RUN;
      end
      else
      begin
         // mode transitions: timer runs while requested differs from active
         for (int i = 0; i < BMPC_NCH; i++)
         begin
            if (done_w[i])
            begin
               nxt_s.act[2*i +: 2] = s_ff.mode[2*i +: 2];
               nxt_s.cnt[i]        = 16'h0000;
               // only pwm/pfm swaps raise the flag, enables do not
               if (s_ff.act[2*i +: 2] != BMPC_MODE_OFF && s_ff.mode[2*i +: 2] != BMPC_MODE_OFF)
                  set[i] = 1'b1;
            end
            else if (s_ff.act[2*i +: 2] != s_ff.mode[2*i +: 2])
               nxt_s.cnt[i] = s_ff.cnt[i] + 16'h0001;
            else
               nxt_s.cnt[i] = 16'h0000;
         end
         // ahb-lite data phase
         if (s_ff.dph_v && s_ff.dph_wr)
         begin
            case (s_ff.dph_a)
               BMPC_OFS_MODE:     nxt_s.mode   = hwdata[7:0];
               BMPC_OFS_ILIM:     nxt_s.ilim   = hwdata[7:0];
               BMPC_OFS_PHASE:    nxt_s.ph     = hwdata[11:0];
               BMPC_OFS_STBY:     nxt_s.stby   = hwdata[7:0];
               BMPC_OFS_IRQ_MASK: nxt_s.mask   = hwdata[3:0];
               default: ;
            endcase
         end
         // write-one clears, but a fresh event wins over the clear
         if (s_ff.dph_v && s_ff.dph_wr && s_ff.dph_a == BMPC_OFS_IRQ_STAT)
            nxt_s.stat = (s_ff.stat & ~hwdata[3:0]) | set;
         else
            nxt_s.stat = s_ff.stat | set;
      end
      // address phase capture
      nxt_s.dph_v  = hsel && htrans[1] && hready;
      nxt_s.dph_wr = hwrite;
      nxt_s.dph_a  = {haddr[7:2], 2'b00};
      if (hsel && htrans[1] && hready && !hwrite)
      begin
         case ({haddr[7:2], 2'b00})
            BMPC_OFS_MODE:     rd = {24'h0, s_ff.mode};
            BMPC_OFS_ILIM:     rd = {24'h0, s_ff.ilim};
            BMPC_OFS_PHASE:    rd = {20'h0, s_ff.ph};
            BMPC_OFS_STBY:     rd = {24'h0, s_ff.stby};
            BMPC_OFS_PAIR:     rd = {28'h0, s_ff.pair_b, s_ff.pair_a};
            BMPC_OFS_IRQ_STAT: rd = {28'h0, s_ff.stat};
            BMPC_OFS_IRQ_MASK: rd = {28'h0, s_ff.mask};
            BMPC_OFS_ACT_MODE: rd = {24'h0, s_ff.act};
            default:           rd = 32'h0000_0000;
         endcase
      end
      nxt_s.rdata = rd;
      // pin low while any unmasked flag is pending
      nxt_s.irq_n = ~|(nxt_s.stat & ~nxt_s.mask);
      // pairing: primary settings drive the secondary, phases stay own
      nxt_s.o_mode = nxt_s.act;
      nxt_s.o_ilim = nxt_s.ilim;
      nxt_s.o_ph   = nxt_s.ph;
      if (nxt_s.pair_a == BMPC_PAIR_DUAL)
      begin
         nxt_s.o_mode[3:2] = nxt_s.act[1:0];
         nxt_s.o_ilim[3:2] = nxt_s.ilim[1:0];
      end                                                                     // else own
      if (nxt_s.pair_b == BMPC_PAIR_DUAL)
      begin
         nxt_s.o_mode[7:6] = nxt_s.act[5:4];
         nxt_s.o_ilim[7:6] = nxt_s.ilim[5:4];
      end                                                                     // else own
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s_ff        <= '0;
         s_ff.st     <= ST_LOAD;
         s_ff.mask   <= BMPC_MASK_RST;
         s_ff.irq_n  <= 1'b1;
      end
      else if (clk_en)
         s_ff <= nxt_s;
   end

   assign hrdata    = s_ff.rdata;
   assign hreadyout = 1'b1;   // zero wait states
   assign hresp     = 1'b0;
   assign eff_mode  = s_ff.o_mode;
   assign eff_ilim  = s_ff.o_ilim;
   assign eff_phase = s_ff.o_ph;
   assign irq_out_n = s_ff.irq_n;

   // decoded values registered so outputs stay flop-driven
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ilim_ma   <= '0;
         phase_deg <= '0;
      end
      else if (clk_en)
      begin
         ilim_ma   <= ma_w;
         phase_deg <= deg_w;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_req_diff;
      s_ff.st == ST_RUN && s_ff.act[1:0] != s_ff.mode[1:0];
   endsequence

   settle_lower_a: assert property (@(posedge clk) disable iff (reset || !clk_en)
      s_ff.cnt[0] != 16'h0000 |-> s_ff.cnt[0] <= 16'(SETTLE_CYC))
      else $error("transition timer overran settle count");

   settle_done_a: assert property (@(posedge clk) disable iff (reset || !clk_en)
      $rose(s_ff.stat[0]) |-> $past(done_w[0]))
      else $error("flag set before transition finished");

   flag_sticky_a: assert property (@(posedge clk) disable iff (reset || !clk_en)
      s_ff.stat[1] && !(s_ff.dph_v && s_ff.dph_wr && s_ff.dph_a == BMPC_OFS_IRQ_STAT)
      |=> s_ff.stat[1])
      else $error("flag dropped without clear");

   irq_gate_a: assert property (@(posedge clk) disable iff (reset)
      s_ff.st == ST_RUN |-> irq_out_n == ~|(s_ff.stat & ~s_ff.mask))
      else $error("irq pin not matching masked flags");

   pair_a_follow_a: assert property (@(posedge clk) disable iff (reset)
      s_ff.st == ST_RUN && a_dual && $stable(s_ff.ilim) |-> eff_ilim[3:2] == s_ff.ilim[1:0])
      else $error("secondary ignores primary in pair a");

   pair_b_indep_a: assert property (@(posedge clk) disable iff (reset)
      s_ff.st == ST_RUN && !b_dual && $stable(s_ff.ilim) |-> eff_ilim[7:6] == s_ff.ilim[7:6])
      else $error("pair b not independent in single mode");

   phase_own_a: assert property (@(posedge clk) disable iff (reset)
      s_ff.st == ST_RUN && $stable(s_ff.ph) |-> eff_phase == s_ff.ph)
      else $error("phase not per channel");

   load_stby_a: assert property (@(posedge clk) disable iff (!clk_en)
      s_ff.st == ST_LOAD && !reset |=> s_ff.stby[1:0] == ($past(otp.stby_def[0]) ? BMPC_MODE_PFM : BMPC_MODE_OFF))
      else $error("standby default not loaded");

   load_ilim_a: assert property (@(posedge clk) disable iff (!clk_en)
      s_ff.st == ST_LOAD && !reset |=> s_ff.ilim[1:0] == $past(otp.ilim_def[0]))
      else $error("limit default not loaded");

   wait_len_a: assert property (@(posedge clk) disable iff (reset || !clk_en)
      s_req_diff ##1 s_ff.act[1:0] == $past(s_ff.mode[1:0]) && $past(s_ff.act[1:0]) != s_ff.act[1:0]
      |-> $past(s_ff.cnt[0]) == 16'(SETTLE_CYC - 1))
      else $error("mode applied early");

   // reserved pair codes must leave the secondary on its own settings
   pair_rsv_a: assert property (@(posedge clk) disable iff (reset)
      s_ff.st == ST_RUN && s_ff.pair_a[1] |-> eff_ilim[3:2] == s_ff.ilim[3:2] && eff_mode[3:2] == s_ff.act[3:2])
      else $error("reserved pair code joined the channels");

   // a low enable must leave every state bit where it was
   hold_en_a: assert property (@(posedge clk) disable iff (reset)
      !$past(clk_en) && !$past(reset) |-> $stable(s_ff))
      else $error("state moved while enable was low");

endmodule // bmpc_top

/* File: bmpc_pkg.sv */
// shared constants and types for the buck mode and phase configuration block
package bmpc_pkg;

   // ---------------------------------------------------------------
   // geometry and timing
   // ---------------------------------------------------------------
   localparam int          BMPC_NCH            = 4;
   localparam int          BMPC_CLK_MHZ        = 25;
   localparam int          BMPC_PFM2PWM_MIN_US = 10;
   localparam int          BMPC_PFM2PWM_MAX_US = 50;
   localparam int          BMPC_PFM2PWM_MIN_CYC = BMPC_PFM2PWM_MIN_US * BMPC_CLK_MHZ;
   localparam int          BMPC_PFM2PWM_MAX_CYC = BMPC_PFM2PWM_MAX_US * BMPC_CLK_MHZ;
   localparam int          BMPC_SETTLE_CYC     = (BMPC_PFM2PWM_MIN_CYC + BMPC_PFM2PWM_MAX_CYC) / 2;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0]  BMPC_OFS_MODE       = 8'h00;
   localparam logic [7:0]  BMPC_OFS_ILIM       = 8'h04;
   localparam logic [7:0]  BMPC_OFS_PHASE      = 8'h08;
   localparam logic [7:0]  BMPC_OFS_STBY       = 8'h0C;
   localparam logic [7:0]  BMPC_OFS_PAIR       = 8'h10;
   localparam logic [7:0]  BMPC_OFS_IRQ_STAT   = 8'h14;
   localparam logic [7:0]  BMPC_OFS_IRQ_MASK   = 8'h18;
   localparam logic [7:0]  BMPC_OFS_ACT_MODE   = 8'h1C;

   // ---------------------------------------------------------------
   // field layout and encodings
   // ---------------------------------------------------------------
   localparam int          BMPC_MODE_W         = 2;
   localparam int          BMPC_ILIM_W         = 2;
   localparam int          BMPC_PH_W           = 3;
   localparam logic [1:0]  BMPC_MODE_OFF       = 2'h0;
   localparam logic [1:0]  BMPC_MODE_PWM       = 2'h1;
   localparam logic [1:0]  BMPC_MODE_PFM       = 2'h2;
   localparam logic [1:0]  BMPC_PAIR_SINGLE    = 2'h0;
   localparam logic [1:0]  BMPC_PAIR_DUAL      = 2'h1;
   localparam logic [3:0]  BMPC_MASK_RST       = 4'hF;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  [1:0] ilim_def;
      logic [11:0]       ph_def;
      logic [3:0]        stby_def;
      logic [1:0]        pair_a;
      logic [1:0]        pair_b;
   } bmpc_otp_t;

   typedef struct packed {
      logic [7:0]  haddr;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [1:0]  htrans;
      logic        hsel;
   } bmpc_ahb_req_t;

endpackage

/* File: bmpc_ilim_decode.sv */
// current limit code to milliamp decode for one channel
`timescale 1ns/1ps
module bmpc_ilim_decode
   import bmpc_pkg::*;
(
   input  wire logic [1:0]  code,
   output logic      [12:0] limit_ma
);
   // 00 and 11 both give the top limit
   always_comb
   begin
      case (code)
         2'h1:    limit_ma = 13'h0A28;  // 2600 mA
         2'h2:    limit_ma = 13'h0BB8;  // 3000 mA
         default: limit_ma = 13'h1194;  // 4500 mA
      endcase
   end
endmodule // bmpc_ilim_decode

/* File: bmpc_phase_decode.sv */
// phase select code to degrees decode for one channel
`timescale 1ns/1ps
module bmpc_phase_decode
   import bmpc_pkg::*;
(
   input  wire logic [2:0] code,
   output logic      [8:0] degrees
);
   // 45 degree steps, code 7 wraps to zero
   always_comb
   begin
      if (code == 3'h7)
         degrees = 9'h000;
      else
         degrees = 9'(({6'h00, code} + 9'h001) * 9'h02D);
   end
endmodule // bmpc_phase_decode

/* File: bmpc_host.sv */
// ahb-lite master model standing in for the host microcontroller
`timescale 1ns/1ps
module bmpc_host
   import bmpc_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          hready,
   input  wire logic [31:0]   hrdata,
   output bmpc_ahb_req_t      req,
   output logic      [31:0]   hwdata
);
   // ------------------------------------------------------------
   // single word transfers
   // ------------------------------------------------------------
   initial
   begin
      req    = '0;
      hwdata = '0;
   end

   // every change lands just after a rising edge and holds until hready
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      req <= '{haddr: a, hwrite: wr, hsize: 3'h2, htrans: 2'h2, hsel: 1'b1};
      do @(posedge clk); while (hready !== 1'b1);
      req.htrans <= 2'h0;
      req.hsel   <= 1'b0;
      hwdata     <= wr ? d : ~hwdata;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
      // released data must not keep showing the last value
      hwdata <= ~hwdata;
   endtask
endmodule // bmpc_host

/* File: test_buck_mode_phase_config.sv */
// self-checking testbench for the buck mode and phase configuration block
`timescale 1ns/1ps
module test_buck_mode_phase_config;
   import bmpc_pkg::*;
   localparam int SIM_SETTLE = 4;
   logic          clk;
   logic          reset;
   logic          clk_en;
   logic          hresp;
   bmpc_otp_t     otp;
   bmpc_ahb_req_t req;
   logic [31:0]   hwdata;
   logic [31:0]   hrdata;
   logic          hreadyout;
   logic [7:0]    eff_mode;
   logic [7:0]    eff_ilim;
   logic [11:0]   eff_phase;
   logic [51:0]   ilim_ma;
   logic [35:0]   phase_deg;
   logic          irq_out_n;
   int            bad_count;
   int            n_tests;
   int            n;

   // ------------------------------------------------------------
   // clock, design and host
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // short settle count keeps the mode-change runs brief
   bmpc_top #(.SETTLE_CYC(SIM_SETTLE)) i_bmpc_top (.clk(clk), .reset(reset), .clk_en(clk_en), .otp(otp),
      .hsel(req.hsel), .haddr(req.haddr), .htrans(req.htrans), .hwrite(req.hwrite), .hsize(req.hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .eff_mode(eff_mode), .eff_ilim(eff_ilim), .eff_phase(eff_phase), .ilim_ma(ilim_ma),
      .phase_deg(phase_deg), .irq_out_n(irq_out_n));

   bmpc_host i_bmpc_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .req(req), .hwdata(hwdata));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic close_out();
      if (bad_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      i_bmpc_host.xfer(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      i_bmpc_host.xfer(1'b0, a, 32'h0, q);
      chk(nm, e, q);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   // the pin is registered from the next status and mask values, in the same cycle as their flops
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clk);
      chk("irq_out_n", {31'h0, e}, {31'h0, irq_out_n});
   endtask

   task automatic do_reset();
      reset <= 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // expected decodes per channel: limit in milliamps, phase in degrees
   task automatic chk_dec(input logic [7:0] il, input logic [11:0] ph);
      logic [1:0] c;
      logic [2:0] p;
      for (int i = 0; i < 4; i++)
      begin
         c = il[2*i +: 2];
         p = ph[3*i +: 3];
         chk("ilim_ma", (c == 2'h1) ? 32'd2600 : (c == 2'h2) ? 32'd3000 : 32'd4500, 32'(ilim_ma[13*i +: 13]));
         chk("phase_deg", (p == 3'h7) ? 32'd0 : 32'(p + 1) * 45, 32'(phase_deg[9*i +: 9]));
      end
   endtask

   // ------------------------------------------------------------
   // watchdog and main sequence
   // ------------------------------------------------------------
   initial
   begin
      #(40 * 8000);
      bad_count++;
      close_out();
   end

   initial
   begin
      bad_count = 0;
      n_tests   = 0;
      reset     = 1'b1;
      clk_en    = 1'b1;
      otp       = '0;
      otp.ilim_def[0] = 2'h1;
      otp.ilim_def[1] = 2'h2;
      otp.ilim_def[2] = 2'h3;
      otp.ph_def      = 12'hFA8;
      otp.stby_def    = 4'h5;
      do_reset();
      // limit, phase and standby defaults come from the programmed fields, the mask from reset
      rd_chk("ilim reg", BMPC_OFS_ILIM, 32'h39);
      rd_chk("phase reg", BMPC_OFS_PHASE, 32'hFA8);
      rd_chk("stby reg", BMPC_OFS_STBY, 32'h22);
      rd_chk("mask reg", BMPC_OFS_IRQ_MASK, 32'hF);
      chk_dec(8'h39, 12'hFA8);
      // pwm to pfm on two channels, only channel zero unmasked
      wr(BMPC_OFS_MODE, 32'h55);
      repeat (SIM_SETTLE + 6) @(posedge clk);
      wr(BMPC_OFS_IRQ_STAT, 32'hF);
      wr(BMPC_OFS_IRQ_MASK, 32'hE);
      rd_chk("stat clear", BMPC_OFS_IRQ_STAT, 32'h0);
      wr(BMPC_OFS_MODE, 32'h5A);
      chk("irq early", 32'h1, {31'h0, irq_out_n});
      rd_chk("act before", BMPC_OFS_ACT_MODE, 32'h55);
      n = 0;
      while (irq_out_n !== 1'b0 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      chk("settle window", 32'h1, {31'h0, n >= 2 && n <= SIM_SETTLE + 3});
      rd_chk("stat set", BMPC_OFS_IRQ_STAT, 32'h3);
      rd_chk("act after", BMPC_OFS_ACT_MODE, 32'h5A);
      wr(BMPC_OFS_IRQ_MASK, 32'hF);
      irq_chk(1'b1);
      rd_chk("stat sticky", BMPC_OFS_IRQ_STAT, 32'h3);
      wr(BMPC_OFS_IRQ_STAT, 32'h1);
      rd_chk("stat w1c", BMPC_OFS_IRQ_STAT, 32'h2);
      wr(BMPC_OFS_IRQ_MASK, 32'hD);
      irq_chk(1'b0);
      wr(BMPC_OFS_IRQ_STAT, 32'h2);
      irq_chk(1'b1);
      // a change into off is not a pwm/pfm change and raises no flag
      wr(BMPC_OFS_MODE, 32'h58);
      repeat (SIM_SETTLE + 8) @(posedge clk);
      rd_chk("stat off", BMPC_OFS_IRQ_STAT, 32'h0);
      rd_chk("act off", BMPC_OFS_ACT_MODE, 32'h58);
      // unmapped and read-only places
      wr(8'h20, 32'hFF);
      rd_chk("unmapped", 8'h20, 32'h0);
      wr(BMPC_OFS_ACT_MODE, 32'h0);
      rd_chk("act ro", BMPC_OFS_ACT_MODE, 32'h58);
      wr(BMPC_OFS_PAIR, 32'hF);
      rd_chk("pair ro", BMPC_OFS_PAIR, 32'h0);
      // a low enable freezes a pending mode change, which resumes after
      wr(BMPC_OFS_MODE, 32'h5A);
      clk_en <= 1'b0;
      repeat (SIM_SETTLE + 4) @(posedge clk);
      chk("eff_mode frozen", 32'h58, 32'(eff_mode));
      clk_en <= 1'b1;
      repeat (SIM_SETTLE + 2) @(posedge clk);
      chk("eff_mode resumed", 32'h5A, 32'(eff_mode));
      // every pairing code on both pairs; only 01 joins a pair
      for (int cfg = 0; cfg < 4; cfg++)
      begin
         otp.pair_a <= 2'(cfg);
         otp.pair_b <= 2'(cfg);
         do_reset();
         rd_chk("pair reg", BMPC_OFS_PAIR, 32'(cfg * 5));
         wr(BMPC_OFS_ILIM, 32'h39);
         wr(BMPC_OFS_PHASE, 32'h8D1);
         wr(BMPC_OFS_MODE, 32'h11);
         repeat (SIM_SETTLE + 3) @(posedge clk);
         chk("eff_ilim", (cfg == 1) ? 32'hF5 : 32'h39, 32'(eff_ilim));
         chk("eff_mode", (cfg == 1) ? 32'h55 : 32'h11, 32'(eff_mode));
         chk("eff_phase", 32'h8D1, 32'(eff_phase));
         chk_dec((cfg == 1) ? 8'hF5 : 8'h39, 12'h8D1);
      end
      close_out();
   end
endmodule // test_buck_mode_phase_config
